/* src/dpvd_pkg.sv */
// dual-panel video dma: register map, field layout, state and bus carriers
// assumes a single memory clock and a 32-bit axi4-lite register bus
// Function
// - first quadword fetched feeds upper panel, second feeds lower panel
// - straddling cursor: vstart ends the lower panel span, vend starts the upper span
// - straddling cursor shows lower from display_vstart, upper up to display_vend
// - in dual-panel mode fetches are always issued as pairs
// - writing bit 7 of video_dma_control selects duplex mode
// - video_dma_control bit 5 enables dma, bit 7 duplex, rest undefined
// - duplex fetches two quadwords, from up_ptr then lo_ptr, two streams
// - duplex transfers are single quadwords, pointers step by 0x10
// - upper pointer may sit in lower half; streams wrap within buffer
// - pointer equal to buffer end carries last flag at bit 30, honoured
package dpvd_pkg;

  localparam int AW = 12;

  localparam logic [AW-1:0] OFS_FB_START = 12'h1C0;
  localparam logic [AW-1:0] OFS_FB_END   = 12'h1C4;
  localparam logic [AW-1:0] OFS_UP_PTR   = 12'h1C8;
  localparam logic [AW-1:0] OFS_LO_PTR   = 12'h1CC;
  localparam logic [AW-1:0] OFS_CUR_VS   = 12'h1D0;
  localparam logic [AW-1:0] OFS_CUR_VE   = 12'h1D4;
  localparam logic [AW-1:0] OFS_DSP_VS   = 12'h1D8;
  localparam logic [AW-1:0] OFS_DSP_VE   = 12'h1DC;
  localparam logic [AW-1:0] OFS_CTRL     = 12'h1E0;
  localparam logic [AW-1:0] OFS_UP_CUR   = 12'h1E4;
  localparam logic [AW-1:0] OFS_LO_CUR   = 12'h1E8;

  localparam int CTRL_EN_BIT   = 5;
  localparam int CTRL_DUP_BIT  = 7;
  localparam int PTR_LAST_BIT  = 30;
  localparam int CUR_MODE_LO   = 13;
  localparam int RASTER_W      = 13;

  localparam logic [31:0] PTR_ADDR_MASK = 32'h3FFF_FFF0;
  localparam logic [31:0] QWORD_STEP    = 32'h0000_0010;

  localparam logic [1:0] CUR_OFF      = 2'h0;
  localparam logic [1:0] CUR_UPPER    = 2'h1;
  localparam logic [1:0] CUR_LOWER    = 2'h2;
  localparam logic [1:0] CUR_STRADDLE = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DPVD_IDLE,
    DPVD_FETCH_UP,
    DPVD_FETCH_LO
  } dpvd_fsm_e;

  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } dpvd_axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dpvd_axil_rsp_s;

  typedef struct packed {
    logic           aw_ok;
    logic [AW-1:0]  aw_addr;
    logic           w_ok;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    dpvd_axil_rsp_s rsp;
    logic [7:0]     ctrl;
    logic [31:0]    fb_start;
    logic [31:0]    fb_end;
    logic [31:0]    up_init;
    logic [31:0]    lo_init;
    logic [31:0]    cur_vs;
    logic [31:0]    cur_ve;
    logic [31:0]    dsp_vs;
    logic [31:0]    dsp_ve;
    dpvd_fsm_e      fsm;
    logic           pend;
    logic [31:0]    up_ptr;
    logic [31:0]    lo_ptr;
    logic           up_last;
    logic           lo_last;
    logic           fetch_valid;
    logic [31:0]    fetch_addr;
    logic           fetch_lower;
    logic           show_up;
    logic           show_lo;
  } dpvd_state_s;

  localparam dpvd_state_s ST_RESET = '0;

endpackage

/* src/dpvd_video_dma.sv */
// dual-panel video dma sequencer with axi4-lite register slave
// assumes memory accepts one fetch address per fetch_valid/fetch_ready handshake
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module dpvd_video_dma (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire dpvd_pkg::dpvd_axil_req_s         axil_req,
  output dpvd_pkg::dpvd_axil_rsp_s              axil_rsp,
  input  wire logic                             vid_req,
  output logic                                  fetch_valid,
  output logic [31:0]                           fetch_addr,
  output logic                                  fetch_lower,
  input  wire logic                             fetch_ready,
  input  wire logic [dpvd_pkg::RASTER_W-1:0]    panel_raster,
  output logic                                  cursor_show_upper,
  output logic                                  cursor_show_lower
);

  dpvd_pkg::dpvd_state_s st_reg;
  dpvd_pkg::dpvd_state_s st_next;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // wrap to buffer start at the end mark or the software last flag
  function automatic logic [31:0] step_ptr(input logic [31:0] ptr, input logic last,
                                           input logic [31:0] fb_s, input logic [31:0] fb_e);
    logic [31:0] r;
    r = ptr + dpvd_pkg::QWORD_STEP;
    if (last || (ptr == (fb_e & dpvd_pkg::PTR_ADDR_MASK))) begin
      r = fb_s & dpvd_pkg::PTR_ADDR_MASK;
    end
    return r;
  endfunction

  logic                          en;
  logic                          dup;
  logic [1:0]                    cur_mode;
  logic [dpvd_pkg::RASTER_W-1:0] r_cvs;
  logic [dpvd_pkg::RASTER_W-1:0] r_cve;
  logic [dpvd_pkg::RASTER_W-1:0] r_dvs;
  logic [dpvd_pkg::RASTER_W-1:0] r_dve;
  logic                          fetch_taken;

  assign en          = st_reg.ctrl[dpvd_pkg::CTRL_EN_BIT];
  assign dup         = st_reg.ctrl[dpvd_pkg::CTRL_DUP_BIT];
  assign cur_mode    = st_reg.cur_vs[dpvd_pkg::CUR_MODE_LO +: 2];
  assign r_cvs       = st_reg.cur_vs[dpvd_pkg::RASTER_W-1:0];
  assign r_cve       = st_reg.cur_ve[dpvd_pkg::RASTER_W-1:0];
  assign r_dvs       = st_reg.dsp_vs[dpvd_pkg::RASTER_W-1:0];
  assign r_dve       = st_reg.dsp_ve[dpvd_pkg::RASTER_W-1:0];
  assign fetch_taken = st_reg.fetch_valid && fetch_ready;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic [31:0] ctrl_w;
    rd      = '0;
    hit     = 1'b1;
    ctrl_w  = '0;
    st_next = st_reg;

    // register slave: address and data may arrive in either order
    if (axil_req.awvalid && st_reg.rsp.awready) begin
      st_next.aw_ok   = 1'b1;
      st_next.aw_addr = axil_req.awaddr;
    end
    if (axil_req.wvalid && st_reg.rsp.wready) begin
      st_next.w_ok  = 1'b1;
      st_next.wdata = axil_req.wdata;
      st_next.wstrb = axil_req.wstrb;
    end
    if (st_reg.rsp.bvalid && axil_req.bready) begin
      st_next.rsp.bvalid = 1'b0;
    end
    if (st_reg.aw_ok && st_reg.w_ok) begin
      st_next.aw_ok         = 1'b0;
      st_next.w_ok          = 1'b0;
      st_next.rsp.bvalid    = 1'b1;
      st_next.rsp.bresp     = dpvd_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        dpvd_pkg::OFS_CTRL: begin
          ctrl_w       = merge_bytes({24'h000000, st_reg.ctrl}, st_reg.wdata, st_reg.wstrb);
          st_next.ctrl = ctrl_w[7:0];
        end
        dpvd_pkg::OFS_FB_START: st_next.fb_start = merge_bytes(st_reg.fb_start, st_reg.wdata, st_reg.wstrb);
        dpvd_pkg::OFS_FB_END:   st_next.fb_end   = merge_bytes(st_reg.fb_end, st_reg.wdata, st_reg.wstrb);
        dpvd_pkg::OFS_UP_PTR:   st_next.up_init  = merge_bytes(st_reg.up_init, st_reg.wdata, st_reg.wstrb);
        dpvd_pkg::OFS_LO_PTR:   st_next.lo_init  = merge_bytes(st_reg.lo_init, st_reg.wdata, st_reg.wstrb);
        dpvd_pkg::OFS_CUR_VS:   st_next.cur_vs   = merge_bytes(st_reg.cur_vs, st_reg.wdata, st_reg.wstrb);
        dpvd_pkg::OFS_CUR_VE:   st_next.cur_ve   = merge_bytes(st_reg.cur_ve, st_reg.wdata, st_reg.wstrb);
        dpvd_pkg::OFS_DSP_VS:   st_next.dsp_vs   = merge_bytes(st_reg.dsp_vs, st_reg.wdata, st_reg.wstrb);
        dpvd_pkg::OFS_DSP_VE:   st_next.dsp_ve   = merge_bytes(st_reg.dsp_ve, st_reg.wdata, st_reg.wstrb);
        default:                st_next.rsp.bresp = dpvd_pkg::RESP_SLVERR;
      endcase
    end

    if (st_reg.rsp.rvalid && axil_req.rready) begin
      st_next.rsp.rvalid = 1'b0;
    end
    if (axil_req.arvalid && st_reg.rsp.arready) begin
      unique case (axil_req.araddr)
        dpvd_pkg::OFS_CTRL:     rd = {24'h000000, st_reg.ctrl};
        dpvd_pkg::OFS_FB_START: rd = st_reg.fb_start;
        dpvd_pkg::OFS_FB_END:   rd = st_reg.fb_end;
        dpvd_pkg::OFS_UP_PTR:   rd = st_reg.up_init;
        dpvd_pkg::OFS_LO_PTR:   rd = st_reg.lo_init;
        dpvd_pkg::OFS_CUR_VS:   rd = st_reg.cur_vs;
        dpvd_pkg::OFS_CUR_VE:   rd = st_reg.cur_ve;
        dpvd_pkg::OFS_DSP_VS:   rd = st_reg.dsp_vs;
        dpvd_pkg::OFS_DSP_VE:   rd = st_reg.dsp_ve;
        dpvd_pkg::OFS_UP_CUR:   rd = st_reg.up_ptr;
        dpvd_pkg::OFS_LO_CUR:   rd = st_reg.lo_ptr;
        default:                hit = 1'b0;
      endcase
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata  = rd;
      st_next.rsp.rresp  = hit ? dpvd_pkg::RESP_OKAY : dpvd_pkg::RESP_SLVERR;
    end
    st_next.rsp.awready = !st_next.aw_ok && !st_next.rsp.bvalid;
    st_next.rsp.wready  = !st_next.w_ok && !st_next.rsp.bvalid;
    st_next.rsp.arready = !st_next.rsp.rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // fetch sequencer
    if (vid_req) begin
      st_next.pend = 1'b1;
    end
    if (!en) begin
      st_next.fsm         = dpvd_pkg::DPVD_IDLE;
      st_next.pend        = 1'b0;
      st_next.fetch_valid = 1'b0;
      st_next.up_ptr      = st_reg.up_init & dpvd_pkg::PTR_ADDR_MASK;
      st_next.lo_ptr      = st_reg.lo_init & dpvd_pkg::PTR_ADDR_MASK;
      st_next.up_last     = st_reg.up_init[dpvd_pkg::PTR_LAST_BIT];
      st_next.lo_last     = st_reg.lo_init[dpvd_pkg::PTR_LAST_BIT];
    end else begin
      unique case (st_reg.fsm)
        dpvd_pkg::DPVD_IDLE: begin
          if (vid_req || st_reg.pend) begin
            st_next.pend        = 1'b0;
            st_next.fsm         = dpvd_pkg::DPVD_FETCH_UP;
            st_next.fetch_valid = 1'b1;
            st_next.fetch_addr  = st_reg.up_ptr;
            st_next.fetch_lower = 1'b0;
          end
        end
        dpvd_pkg::DPVD_FETCH_UP: begin
          if (fetch_taken) begin
            st_next.up_ptr  = step_ptr(st_reg.up_ptr, st_reg.up_last, st_reg.fb_start, st_reg.fb_end);
            st_next.up_last = 1'b0;
            if (dup) begin
              st_next.fsm         = dpvd_pkg::DPVD_FETCH_LO;
              st_next.fetch_addr  = st_reg.lo_ptr;
              st_next.fetch_lower = 1'b1;
            end else begin
              st_next.fsm         = dpvd_pkg::DPVD_IDLE;
              st_next.fetch_valid = 1'b0;
            end
          end
        end
        dpvd_pkg::DPVD_FETCH_LO: begin
          if (fetch_taken) begin
            st_next.lo_ptr      = step_ptr(st_reg.lo_ptr, st_reg.lo_last, st_reg.fb_start, st_reg.fb_end);
            st_next.lo_last     = 1'b0;
            st_next.fsm         = dpvd_pkg::DPVD_IDLE;
            st_next.fetch_valid = 1'b0;
          end
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // cursor placement per panel
    unique case (cur_mode)
      dpvd_pkg::CUR_STRADDLE: begin
        st_next.show_lo = (panel_raster >= r_dvs) && (panel_raster < r_cvs);
        st_next.show_up = (panel_raster >= r_cve) && (panel_raster < r_dve);
      end
      dpvd_pkg::CUR_LOWER: begin
        st_next.show_lo = (panel_raster >= r_cvs) && (panel_raster < r_cve);
        st_next.show_up = 1'b0;
      end
      default: begin
        st_next.show_lo = 1'b0;
        st_next.show_up = (panel_raster >= r_cvs) && (panel_raster < r_cve);
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= dpvd_pkg::ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign axil_rsp          = st_reg.rsp;
  assign fetch_valid       = st_reg.fetch_valid;
  assign fetch_addr        = st_reg.fetch_addr;
  assign fetch_lower       = st_reg.fetch_lower;
  assign cursor_show_upper = st_reg.show_up;
  assign cursor_show_lower = st_reg.show_lo;

  ////////////////////////////////////////////////////////////////////////////
  property p_pair_follows;
    @(posedge aclk) disable iff (!aresetn)
    (en && dup && st_reg.fsm == dpvd_pkg::DPVD_FETCH_UP && fetch_taken) |=> (fetch_valid && fetch_lower);
  endproperty
  a_pair_follows: assert property (p_pair_follows) else $error("lower fetch did not follow upper");

  property p_upper_first;
    @(posedge aclk) disable iff (!aresetn)
    (en && st_reg.fsm == dpvd_pkg::DPVD_IDLE && vid_req) |=> (fetch_valid && !fetch_lower);
  endproperty
  a_upper_first: assert property (p_upper_first) else $error("first fetch of pair not upper");

  property p_lower_addr;
    @(posedge aclk) disable iff (!aresetn)
    (en && dup && st_reg.fsm == dpvd_pkg::DPVD_FETCH_UP && fetch_taken) |=> (fetch_addr == $past(st_reg.lo_ptr));
  endproperty
  a_lower_addr: assert property (p_lower_addr) else $error("lower fetch address wrong");

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
    (en && st_reg.fsm == dpvd_pkg::DPVD_FETCH_UP && fetch_taken && !st_reg.up_last &&
     st_reg.up_ptr != (st_reg.fb_end & dpvd_pkg::PTR_ADDR_MASK))
    |=> (st_reg.up_ptr == $past(st_reg.up_ptr) + dpvd_pkg::QWORD_STEP);
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step one quadword");

  property p_wrap_end;
    @(posedge aclk) disable iff (!aresetn)
    (en && st_reg.fsm == dpvd_pkg::DPVD_FETCH_LO && fetch_taken &&
     st_reg.lo_ptr == (st_reg.fb_end & dpvd_pkg::PTR_ADDR_MASK))
    |=> (st_reg.lo_ptr == (st_reg.fb_start & dpvd_pkg::PTR_ADDR_MASK));
  endproperty
  a_wrap_end: assert property (p_wrap_end) else $error("stream did not wrap at buffer end");

  property p_last_flag;
    @(posedge aclk) disable iff (!aresetn)
    (en && st_reg.fsm == dpvd_pkg::DPVD_FETCH_UP && fetch_taken && st_reg.up_last)
    |=> (st_reg.up_ptr == (st_reg.fb_start & dpvd_pkg::PTR_ADDR_MASK));
  endproperty
  a_last_flag: assert property (p_last_flag) else $error("last flag not honoured");

  property p_ctrl_write;
    @(posedge aclk) disable iff (!aresetn)
    (st_reg.aw_ok && st_reg.w_ok && st_reg.aw_addr == dpvd_pkg::OFS_CTRL && st_reg.wstrb[0])
    |=> ##1 (dup == $past(st_reg.wdata[dpvd_pkg::CTRL_DUP_BIT], 2));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("duplex bit not written");

  property p_ctrl_read;
    @(posedge aclk) disable iff (!aresetn)
    (axil_req.arvalid && axil_rsp.arready && axil_req.araddr == dpvd_pkg::OFS_CTRL)
    |=> (axil_rsp.rvalid && axil_rsp.rdata[31:8] == 24'h000000);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read has upper bits set");

  property p_straddle;
    @(posedge aclk) disable iff (!aresetn)
    (cur_mode == dpvd_pkg::CUR_STRADDLE && panel_raster >= r_cve && panel_raster < r_dve)
    |=> cursor_show_upper;
  endproperty
  a_straddle: assert property (p_straddle) else $error("straddling cursor missing in upper half");

  property p_straddle_lower;
    @(posedge aclk) disable iff (!aresetn)
    (cur_mode == dpvd_pkg::CUR_STRADDLE && panel_raster >= r_dvs && panel_raster < r_cvs)
    |=> cursor_show_lower;
  endproperty
  a_straddle_lower: assert property (p_straddle_lower) else $error("lower half lacks straddling cursor");

  property p_off_no_fetch;
    @(posedge aclk) disable iff (!aresetn)
    !en |=> !fetch_valid;
  endproperty
  a_off_no_fetch: assert property (p_off_no_fetch) else $error("fetch offered while dma disabled");

  property p_lower_step;
    @(posedge aclk) disable iff (!aresetn)
    (en && st_reg.fsm == dpvd_pkg::DPVD_FETCH_LO && fetch_taken && !st_reg.lo_last &&
     st_reg.lo_ptr != (st_reg.fb_end & dpvd_pkg::PTR_ADDR_MASK))
    |=> (st_reg.lo_ptr == $past(st_reg.lo_ptr) + dpvd_pkg::QWORD_STEP);
  endproperty
  a_lower_step: assert property (p_lower_step) else $error("lower pointer did not step one quadword");

  property p_upper_wrap;
    @(posedge aclk) disable iff (!aresetn)
    (en && st_reg.fsm == dpvd_pkg::DPVD_FETCH_UP && fetch_taken &&
     st_reg.up_ptr == (st_reg.fb_end & dpvd_pkg::PTR_ADDR_MASK))
    |=> (st_reg.up_ptr == (st_reg.fb_start & dpvd_pkg::PTR_ADDR_MASK));
  endproperty
  a_upper_wrap: assert property (p_upper_wrap) else $error("upper stream did not wrap at buffer end");

endmodule

/* test/dpvd_mem_model.sv */
// memory and video macrocell stand-in for the dual-panel video dma
// assumes the bench calls request() and sets stall between transfers
`timescale 1ns/1ps
module dpvd_mem_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        fetch_valid,
  input  wire logic [31:0] fetch_addr,
  input  wire logic        fetch_lower,
  output logic             vid_req,
  output logic             fetch_ready
);
  int          stall;
  int          wait_cnt;
  logic [31:0] addr_log[$];
  logic        lower_log[$];

  initial begin
    vid_req = 1'b0;
    fetch_ready = 1'b0;
    stall = 0;
    wait_cnt = 0;
  end

  // macrocell already set for lcd and duplex: one pulse per line request
  task automatic request();
    @(posedge aclk);
    vid_req <= 1'b1;
    @(posedge aclk);
    vid_req <= 1'b0;
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // accept after stall cycles and log each quadword taken
  always @(posedge aclk) begin
    if (fetch_valid && fetch_ready) begin
      addr_log.push_back(fetch_addr);
      lower_log.push_back(fetch_lower);
    end
    if (!aresetn || fetch_ready || !fetch_valid) begin
      fetch_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (wait_cnt >= stall) begin
      fetch_ready <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

/* test/test_dual_panel_video_dma.sv */
// bench for the dual-panel video dma: registers, fetch pairing, cursor
// assumes dpvd_mem_model as the memory and macrocell side
`timescale 1ns/1ps
module test_dual_panel_video_dma;
  logic                             aclk;
  logic                             aresetn;
  dpvd_pkg::dpvd_axil_req_s         req;
  dpvd_pkg::dpvd_axil_rsp_s         rsp;
  logic                             vid_req;
  logic                             fetch_valid;
  logic [31:0]                      fetch_addr;
  logic                             fetch_lower;
  logic                             fetch_ready;
  logic [dpvd_pkg::RASTER_W-1:0]    panel_raster;
  logic                             cur_up;
  logic                             cur_lo;
  int                               failures;
  int                               checks_done;
  int                               cycles;
  int                               base;
  logic [1:0]                       resp;
  logic [31:0]                      rdata;
  logic [31:0]                      up_exp;
  logic [31:0]                      lo_exp;
  int                               rl[8] = '{9, 10, 29, 30, 49, 50, 199, 200};

  dpvd_video_dma dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .vid_req(vid_req),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_lower(fetch_lower), .fetch_ready(fetch_ready),
    .panel_raster(panel_raster), .cursor_show_upper(cur_up), .cursor_show_lower(cur_lo));
  dpvd_mem_model mem (.aclk(aclk), .aresetn(aresetn), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .fetch_lower(fetch_lower), .vid_req(vid_req), .fetch_ready(fetch_ready));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic axi_write(input logic [dpvd_pkg::AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [dpvd_pkg::AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // pointers reload only while disabled, so enable comes last
  task automatic setup(input logic [31:0] up, input logic [31:0] lo, input logic [7:0] ctrl);
    axi_write(dpvd_pkg::OFS_CTRL, 32'h0000_0000, resp);
    axi_write(dpvd_pkg::OFS_FB_START, 32'h0000_1000, resp);
    axi_write(dpvd_pkg::OFS_FB_END, 32'h0000_10F0, resp);
    axi_write(dpvd_pkg::OFS_UP_PTR, up, resp);
    axi_write(dpvd_pkg::OFS_LO_PTR, lo, resp);
    axi_write(dpvd_pkg::OFS_CTRL, {24'h0, ctrl}, resp);
    up_exp = up & dpvd_pkg::PTR_ADDR_MASK;
    lo_exp = lo & dpvd_pkg::PTR_ADDR_MASK;
  endtask

  // first two requests back to back so the second waits as pending
  task automatic run_pairs(input int n, input int per);
    int k;
    for (int i = 0; i < n; i++) begin
      mem.stall = i % 4;
      mem.request();
      while (i != 0 && mem.addr_log.size() < base + (i + 1) * per) @(posedge aclk);
    end
    repeat (10) @(posedge aclk);
    check(32'(mem.addr_log.size()), 32'(base + n * per));
    for (int i = 0; i < n * per; i++) begin
      k = (per == 2) ? i % 2 : 0;
      check(32'(mem.lower_log[base + i]), 32'(k));
      check(mem.addr_log[base + i], k ? lo_exp : up_exp);
      if (k) lo_exp = (lo_exp == 32'h0000_10F0) ? 32'h0000_1000 : lo_exp + 32'h0000_0010;
      else up_exp = (up_exp == 32'h0000_10F0) ? 32'h0000_1000 : up_exp + 32'h0000_0010;
    end
    base = base + n * per;
  endtask

  // {upper, lower} with cursor_vstart 30, cursor_vend 50, display 10 to 200
  function automatic logic [1:0] cur_exp(input int m, input int r);
    case (m)
      3: return {1'(r >= 50 && r < 200), 1'(r >= 10 && r < 30)};
      2: return {1'b0, 1'(r >= 30 && r < 50)};
      default: return {1'(r >= 30 && r < 50), 1'b0};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    req = '0;
    panel_raster = '0;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    base = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(dpvd_pkg::OFS_CTRL, rdata, resp);
    check(rdata, 32'h0000_0000);
    axi_write(dpvd_pkg::OFS_CTRL, 32'hFFFF_FF7F, resp);
    check(32'(resp), 32'(dpvd_pkg::RESP_OKAY));
    axi_read(dpvd_pkg::OFS_CTRL, rdata, resp);
    check(rdata, 32'h0000_007F);
    axi_write(12'h1F0, 32'h0000_0001, resp);
    check(32'(resp), 32'(dpvd_pkg::RESP_SLVERR));
    axi_read(12'h1F0, rdata, resp);
    check(rdata, 32'h0000_0000);
    check(32'(resp), 32'(dpvd_pkg::RESP_SLVERR));
    axi_write(dpvd_pkg::OFS_UP_CUR, 32'h0000_0010, resp);
    check(32'(resp), 32'(dpvd_pkg::RESP_SLVERR));
    setup(32'h0000_1000, 32'h0000_1080, 8'hA0);
    run_pairs(9, 2);
    setup(32'h4000_10F0, 32'h0000_1070, 8'hA0);
    run_pairs(3, 2);
    setup(32'h0000_1000, 32'h0000_1080, 8'h20);
    run_pairs(2, 1);
    setup(32'h0000_1000, 32'h0000_1080, 8'h80);
    mem.request();
    repeat (10) @(posedge aclk);
    check(32'(mem.addr_log.size()), 32'(base));
    axi_write(dpvd_pkg::OFS_DSP_VS, 32'd10, resp);
    axi_write(dpvd_pkg::OFS_DSP_VE, 32'd200, resp);
    axi_write(dpvd_pkg::OFS_CUR_VE, 32'd50, resp);
    for (int m = 0; m < 4; m++) begin
      axi_write(dpvd_pkg::OFS_CUR_VS, (32'(m) << 13) | 32'd30, resp);
      foreach (rl[j]) begin
        panel_raster <= dpvd_pkg::RASTER_W'(rl[j]);
        repeat (3) @(posedge aclk);
        check({30'h0, cur_up, cur_lo}, 32'(cur_exp(m, rl[j])));
      end
    end
    test_done();
  end
endmodule
